// ### rtl/oag_core.sv
// operand address generator and sequencer
`timescale 1ns/10ps
module oag_core (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // decoder request
  input wire logic start,
  input wire oag_pkg::oag_req_t req,
  output logic ready,
  output logic done,
  // memory bus
  output oag_pkg::oag_mem_t mem,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm_byte,
  // architectural state
  output oag_pkg::oag_arch_t arch,
  output logic [7:0] gen_reg [6]
);

  typedef enum logic [2:0] {
    OAG_ST_IDLE, OAG_ST_STEP1, OAG_ST_STEP2, OAG_ST_STEP3, OAG_ST_WAIT, OAG_ST_SKIP
  } oag_state_t;

  oag_state_t st_r, st_nxt;
  oag_pkg::oag_req_t cur_r, cur_nxt;
  oag_pkg::oag_arch_t a_r, a_nxt;
  oag_pkg::oag_mem_t mem_r, mem_nxt;
  logic [7:0] g_r [6];
  logic [7:0] g_nxt [6];
  logic [15:0] hold_r, hold_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic done_r, done_nxt;
  logic skip_load;
  logic skip_busy;

  // base pair select, used by several modes
  function automatic logic [15:0] pick_pair(input logic use_third, input oag_pkg::oag_arch_t s);
    pick_pair = use_third ? s.third_pointer_pair : s.second_pointer_pair;
  endfunction

  // index value for base index addressing, 8-bit indices zero-extended
  function automatic logic [15:0] pick_index(input oag_pkg::oag_idx_t i, input oag_pkg::oag_arch_t s,
                                              input logic [7:0] first_reg);
    unique case (i)
      oag_pkg::OAG_IDX_ACC: pick_index = {8'h00, s.acc};
      oag_pkg::OAG_IDX_FIRST: pick_index = {8'h00, first_reg};
      oag_pkg::OAG_IDX_WIDE: pick_index = s.wide_accumulator;
      default: pick_index = 16'h0000;
    endcase
  endfunction

  oag_idle_cnt u_idle (
    .mclk(mclk),
    .rstn(rstn),
    .load(skip_load),
    .opc_bytes(cur_r.opc_bytes),
    .imm_bytes(cur_r.imm_bytes),
    .busy(skip_busy)
  );

  // main sequencer; each step issues at most one bus transfer, read data arrives next cycle
  always_comb
  begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    a_nxt = a_r;
    g_nxt = g_r;
    mem_nxt = '0;
    hold_nxt = hold_r;
    wait_nxt = wait_r;
    done_nxt = 1'b0;
    skip_load = 1'b0;
    unique case (st_r)
      OAG_ST_IDLE:
      begin
        if (start)
        begin
          cur_nxt = req;
          st_nxt = OAG_ST_STEP1;
        end
      end
      OAG_ST_STEP1:
      begin
        st_nxt = OAG_ST_WAIT;
        unique case (cur_r.op)
          oag_pkg::OAG_OP_PUSH:
          begin
            a_nxt.stack_pointer = a_r.stack_pointer - 16'h0001;
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: a_r.stack_pointer - 16'h0001, wdata: cur_r.push_data};
          end
          oag_pkg::OAG_OP_TRAP:
          begin
            a_nxt.stack_pointer = a_r.stack_pointer - 16'h0001;
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: a_r.stack_pointer - 16'h0001,
                        wdata: a_r.program_status_word};
            hold_nxt = a_r.program_counter + 16'h0001;
            st_nxt = OAG_ST_STEP2;
          end
          oag_pkg::OAG_OP_STORE_DBL:
          begin
            // low half first at the pointer address
            hold_nxt = pick_pair(cur_r.use_third, a_r);
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: hold_nxt, wdata: a_r.wide_accumulator[7:0]};
            st_nxt = OAG_ST_STEP2;
          end
          oag_pkg::OAG_OP_LOAD_DBL, oag_pkg::OAG_OP_DEC_WORK, oag_pkg::OAG_OP_TABLE:
          begin
            if (cur_r.op == oag_pkg::OAG_OP_LOAD_DBL)
              hold_nxt = pick_pair(cur_r.use_third, a_r);
            else if (cur_r.op == oag_pkg::OAG_OP_DEC_WORK)
              hold_nxt = {a_r.page, cur_r.disp};
            else
              hold_nxt = a_r.program_counter + oag_pkg::TABLE_OFFSET + {8'h00, a_r.acc};
            mem_nxt = '{req: 1'b1, we: 1'b0, addr: hold_nxt, wdata: 8'h00};
            st_nxt = OAG_ST_STEP2;
          end
          oag_pkg::OAG_OP_STORE_BASE:
          begin
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: pick_pair(cur_r.use_third, a_r) + {8'h00, cur_r.disp},
                        wdata: a_r.acc};
          end
          oag_pkg::OAG_OP_STORE_INDEX:
          begin
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: a_r.third_pointer_pair + pick_index(cur_r.idx, a_r, g_r[0]),
                        wdata: a_r.acc};
          end
          oag_pkg::OAG_OP_IMM:
          begin
            a_nxt.acc = imm_byte;
            a_nxt.program_counter = a_r.program_counter + 16'h0001;
          end
          oag_pkg::OAG_OP_IMM_WIDE, oag_pkg::OAG_OP_DIRECT:
          begin
            hold_nxt = {8'h00, imm_byte};
            a_nxt.program_counter = a_r.program_counter + 16'h0001;
            st_nxt = OAG_ST_STEP2;
          end
          oag_pkg::OAG_OP_MOVE:
          begin
            // eight targets: wide upper, wide lower, then six general registers
            if (cur_r.reg_sel == 3'h0)
              a_nxt.wide_accumulator[15:8] = a_r.acc;
            else if (cur_r.reg_sel == 3'h1)
              a_nxt.wide_accumulator[7:0] = a_r.acc;
            else
              g_nxt[cur_r.reg_sel - 3'h2] = a_r.acc;
            a_nxt.bypass_flag = 1'b0;
            a_nxt.load_chain_upper = 1'b0;
            a_nxt.load_chain_lower = 1'b0;
            wait_nxt = 2'(oag_pkg::MOVE_STATES - 2);
          end
          oag_pkg::OAG_OP_SKIP:
          begin
            skip_load = 1'b1;
            st_nxt = OAG_ST_SKIP;
          end
          default:
          begin
            st_nxt = OAG_ST_IDLE;
            done_nxt = 1'b1;
          end
        endcase
      end
      OAG_ST_STEP2:
      begin
        st_nxt = OAG_ST_WAIT;
        unique case (cur_r.op)
          oag_pkg::OAG_OP_TRAP:
          begin
            a_nxt.stack_pointer = a_r.stack_pointer - 16'h0001;
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: a_r.stack_pointer - 16'h0001, wdata: hold_r[15:8]};
            st_nxt = OAG_ST_STEP3;
          end
          oag_pkg::OAG_OP_STORE_DBL:
          begin
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: hold_r + 16'h0001, wdata: a_r.wide_accumulator[15:8]};
            if (cur_r.use_third)
              a_nxt.third_pointer_pair = hold_r + oag_pkg::DOUBLE_STEP;
            else
              a_nxt.second_pointer_pair = hold_r + oag_pkg::DOUBLE_STEP;
          end
          oag_pkg::OAG_OP_LOAD_DBL, oag_pkg::OAG_OP_TABLE:
          begin
            // first byte is on the bus now; request the following one
            if (cur_r.op == oag_pkg::OAG_OP_LOAD_DBL)
              a_nxt.wide_accumulator[7:0] = mem_rdata;
            else
              g_nxt[1] = mem_rdata;
            mem_nxt = '{req: 1'b1, we: 1'b0, addr: hold_r + 16'h0001, wdata: 8'h00};
            st_nxt = OAG_ST_STEP3;
          end
          oag_pkg::OAG_OP_DEC_WORK:
          begin
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: hold_r, wdata: mem_rdata - 8'h01};
          end
          oag_pkg::OAG_OP_IMM_WIDE:
          begin
            a_nxt.first_pair = {imm_byte, hold_r[7:0]};
            a_nxt.program_counter = a_r.program_counter + 16'h0001;
          end
          oag_pkg::OAG_OP_DIRECT:
          begin
            mem_nxt = '{req: 1'b1, we: 1'b0, addr: {imm_byte, hold_r[7:0]}, wdata: 8'h00};
            a_nxt.program_counter = a_r.program_counter + 16'h0001;
            st_nxt = OAG_ST_STEP3;
          end
          default:
          begin
            st_nxt = OAG_ST_IDLE;
          end
        endcase
      end
      OAG_ST_STEP3:
      begin
        st_nxt = OAG_ST_WAIT;
        unique case (cur_r.op)
          oag_pkg::OAG_OP_TRAP:
          begin
            a_nxt.stack_pointer = a_r.stack_pointer - 16'h0001;
            mem_nxt = '{req: 1'b1, we: 1'b1, addr: a_r.stack_pointer - 16'h0001, wdata: hold_r[7:0]};
            a_nxt.program_counter = oag_pkg::TRAP_VECTOR;
          end
          oag_pkg::OAG_OP_LOAD_DBL:
          begin
            a_nxt.wide_accumulator[15:8] = mem_rdata;
            if (cur_r.use_third)
              a_nxt.third_pointer_pair = hold_r + oag_pkg::DOUBLE_STEP;
            else
              a_nxt.second_pointer_pair = hold_r + oag_pkg::DOUBLE_STEP;
          end
          oag_pkg::OAG_OP_TABLE:
          begin
            g_nxt[0] = mem_rdata;
          end
          default:
          begin
            a_nxt.acc = mem_rdata;
          end
        endcase
      end
      OAG_ST_WAIT:
      begin
        // pads short operations out to their state count
        if (wait_r != 2'h0)
          wait_nxt = wait_r - 2'h1;
        else
        begin
          st_nxt = OAG_ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      OAG_ST_SKIP:
      begin
        if (!skip_busy)
        begin
          st_nxt = OAG_ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt = OAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= OAG_ST_IDLE;
      cur_r <= '0;
      a_r <= '0;
      mem_r <= '0;
      g_r <= '{default: 8'h00};
      hold_r <= 16'h0000;
      wait_r <= 2'h0;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      a_r <= a_nxt;
      mem_r <= mem_nxt;
      g_r <= g_nxt;
      hold_r <= hold_nxt;
      wait_r <= wait_nxt;
      done_r <= done_nxt;
    end
  end

  assign ready = (st_r == OAG_ST_IDLE);
  assign done = done_r;
  assign mem = mem_r;
  assign arch = a_r;
  assign gen_reg = g_r;

  // a push lowers the stack pointer by exactly one
  property p_push_dec;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_PUSH) |=>
      a_r.stack_pointer == $past(a_r.stack_pointer) - 16'h0001;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not lower stack pointer");

  sequence s_trap_start;
    st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_TRAP;
  endsequence
  property p_trap_vec;
    @(posedge mclk) disable iff (!rstn)
    s_trap_start |=> ##2 (a_r.program_counter == 16'h0060 && mem_r.we && mem_r.req);
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector or third push wrong");

  property p_dbl_step;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP2 && cur_r.op == oag_pkg::OAG_OP_STORE_DBL) |=>
      (mem_r.addr == hold_r + 16'h0001) && (pick_pair(cur_r.use_third, a_r) == hold_r + 16'h0002);
  endproperty
  a_dbl_step: assert property (p_dbl_step) else $error("double increment wrong");

  property p_base_addr;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_STORE_BASE) |=>
      mem_r.addr == $past(pick_pair(cur_r.use_third, a_r)) + {8'h00, $past(cur_r.disp)}
      && $stable(a_r.third_pointer_pair);
  endproperty
  a_base_addr: assert property (p_base_addr) else $error("base address wrong");

  property p_work_addr;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_DEC_WORK) |=>
      mem_r.addr == {a_r.page, cur_r.disp} && !mem_r.we ##1 mem_r.we && mem_r.addr == {a_r.page, cur_r.disp};
  endproperty
  a_work_addr: assert property (p_work_addr) else $error("working register access wrong");

  property p_table_addr;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_TABLE) |=>
      mem_r.addr == a_r.program_counter + 16'h0003 + {8'h00, a_r.acc};
  endproperty
  a_table_addr: assert property (p_table_addr) else $error("table address wrong");

  property p_move_flags;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_MOVE) |=>
      !a_r.bypass_flag && !a_r.load_chain_upper && !a_r.load_chain_lower ##3 done_r;
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move flags or timing wrong");

  property p_skip_len;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_SKIP && cur_r.opc_bytes == 3'h1 && cur_r.imm_bytes == 3'h0)
      |=> !done_r [*3] ##1 done_r;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip idle count wrong");

  property p_imm_pc;
    @(posedge mclk) disable iff (!rstn)
    (st_r == OAG_ST_STEP1 && cur_r.op == oag_pkg::OAG_OP_IMM) |=>
      a_r.program_counter == $past(a_r.program_counter) + 16'h0001;
  endproperty
  a_imm_pc: assert property (p_imm_pc) else $error("immediate fetch wrong");

endmodule // oag_core

// ### rtl/oag_idle_cnt.sv
// idle state counter for skipped instructions
`timescale 1ns/10ps
module oag_idle_cnt #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // load request
  input wire logic load,
  input wire logic [2:0] opc_bytes,
  input wire logic [2:0] imm_bytes,
  // status
  output logic busy
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] total;

  // load the idle count less the sequencer's own steps, then count down to zero
  always_comb
  begin
    total = W'(opc_bytes * oag_pkg::OPC_IDLE_STATES + imm_bytes * oag_pkg::IMM_IDLE_STATES);
    cnt_nxt = cnt_r;
    if (load)
    begin
      // without the offset a skipped move would take longer than an executed one
      cnt_nxt = (total > W'(oag_pkg::SKIP_STEP_STATES)) ? total - W'(oag_pkg::SKIP_STEP_STATES) : '0;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign busy = (cnt_r != '0);

endmodule // oag_idle_cnt

// ### rtl/oag_pkg.sv
// package for the operand address generation block
package oag_pkg;

  localparam logic [15:0] TRAP_VECTOR = 16'h0060;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int unsigned OPC_IDLE_STATES = 4;
  localparam int unsigned IMM_IDLE_STATES = 3;
  localparam int unsigned MOVE_STATES = 4;
  // the request step and the step that raises done count as idle states of a skip
  localparam int unsigned SKIP_STEP_STATES = 2;
  localparam logic [15:0] DOUBLE_STEP = 16'h0002;
  localparam logic [15:0] TABLE_OFFSET = 16'h0003;

  // operation requested by the decoder
  typedef enum logic [3:0] {
    OAG_OP_NONE, OAG_OP_PUSH, OAG_OP_TRAP, OAG_OP_STORE_DBL, OAG_OP_LOAD_DBL,
    OAG_OP_STORE_BASE, OAG_OP_STORE_INDEX, OAG_OP_DEC_WORK, OAG_OP_TABLE,
    OAG_OP_IMM, OAG_OP_IMM_WIDE, OAG_OP_DIRECT, OAG_OP_MOVE, OAG_OP_SKIP
  } oag_op_t;

  // index source for base index addressing
  typedef enum logic [1:0] {
    OAG_IDX_ACC, OAG_IDX_FIRST, OAG_IDX_WIDE
  } oag_idx_t;

  // instruction request as handed in by the decoder
  typedef struct packed {
    oag_op_t op;
    logic use_third;
    oag_idx_t idx;
    logic [7:0] disp;
    logic [2:0] reg_sel;
    logic [7:0] push_data;
    logic [2:0] opc_bytes;
    logic [2:0] imm_bytes;
  } oag_req_t;

  // one memory bus transfer
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } oag_mem_t;

  // architectural registers visible to the block
  typedef struct packed {
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [7:0] program_status_word;
    logic [15:0] wide_accumulator;
    logic [15:0] second_pointer_pair;
    logic [15:0] third_pointer_pair;
    logic [15:0] first_pair;
    logic [7:0] acc;
    logic [7:0] page;
    logic bypass_flag;
    logic load_chain_upper;
    logic load_chain_lower;
  } oag_arch_t;

endpackage

// ### verif/oag_mem_model.sv
// behavioural byte memory on the far side of the core bus
`timescale 1ns/10ps
module oag_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // core bus
  input wire oag_pkg::oag_mem_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [int];
  logic [7:0] idle_r;

  // unwritten bytes follow an address pattern so stale reads show up
  function automatic logic [7:0] peek(input logic [15:0] a);
    return store.exists(a) ? store[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  // writes land at the edge; an idle bus toggles so a stray read shows up
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      idle_r <= 8'h00;
    else
    begin
      idle_r <= ~idle_r;
      if (mem.req === 1'b1 && mem.we === 1'b1)
        store[mem.addr] = mem.wdata;
    end
  end

  // read data answers in the cycle the request stands, as the sequencer samples it then
  always @*
  begin
    mem_rdata = (mem.req === 1'b1 && mem.we === 1'b0) ? peek(mem.addr) : idle_r;
  end
endmodule // oag_mem_model

// ### verif/operand_address_generation_tb_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generation_tb_top;
  logic mclk;
  logic rstn;
  logic start;
  oag_pkg::oag_req_t req;
  logic ready;
  logic done;
  oag_pkg::oag_mem_t mem;
  logic [7:0] mem_rdata;
  logic [7:0] imm_byte;
  oag_pkg::oag_arch_t arch;
  logic [7:0] gen_reg [6];
  int mismatches;
  int n_compared;
  int cycles;
  logic [24:0] obs [$];
  logic [24:0] expq [$];
  logic [7:0] rmem [int];
  oag_pkg::oag_arch_t ea;
  logic [7:0] eg [6];

  oag_core uut (
    .mclk(mclk), .rstn(rstn), .start(start), .req(req), .ready(ready), .done(done),
    .mem(mem), .mem_rdata(mem_rdata), .imm_byte(imm_byte), .arch(arch), .gen_reg(gen_reg)
  );

  oag_mem_model mem_far (.mclk(mclk), .rstn(rstn), .mem(mem), .mem_rdata(mem_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // every bus transfer is logged; read data field is blanked
  always @(posedge mclk)
  begin
    if (rstn === 1'b1 && mem.req === 1'b1)
      obs.push_back({mem.we, mem.addr, mem.we ? mem.wdata : 8'h00});
  end

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, expd, seen);
    end
  endtask

  function automatic logic [7:0] rd(input logic [15:0] a);
    return rmem.exists(a) ? rmem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
  endfunction

  function automatic void wr(input logic [15:0] a, input logic [7:0] d);
    expq.push_back({1'b1, a, d});
    rmem[a] = d;
  endfunction

  function automatic logic [7:0] rdq(input logic [15:0] a);
    expq.push_back({1'b0, a, 8'h00});
    return rd(a);
  endfunction

  // reference model: expected transfers, state and latency per operation
  task automatic model(input oag_pkg::oag_req_t r, input logic [7:0] lo, input logic [7:0] hi, output int lat);
    logic [15:0] p;
    logic [15:0] t;
    logic [7:0] d;
    p = r.use_third ? ea.third_pointer_pair : ea.second_pointer_pair;
    lat = 5;
    case (r.op)
      oag_pkg::OAG_OP_PUSH:
      begin
        ea.stack_pointer = ea.stack_pointer - 16'h0001;
        wr(ea.stack_pointer, r.push_data);
        lat = 3;
      end
      oag_pkg::OAG_OP_TRAP:
      begin
        t = ea.program_counter + 16'h0001;
        wr(ea.stack_pointer - 16'h0001, ea.program_status_word);
        wr(ea.stack_pointer - 16'h0002, t[15:8]);
        wr(ea.stack_pointer - 16'h0003, t[7:0]);
        ea.stack_pointer = ea.stack_pointer - 16'h0003;
        ea.program_counter = oag_pkg::TRAP_VECTOR;
      end
      oag_pkg::OAG_OP_STORE_DBL, oag_pkg::OAG_OP_LOAD_DBL:
      begin
        // low half at the pointer, high half one above
        if (r.op == oag_pkg::OAG_OP_STORE_DBL)
        begin
          wr(p, ea.wide_accumulator[7:0]);
          wr(p + 16'h0001, ea.wide_accumulator[15:8]);
          lat = 4;
        end
        else
        begin
          d = rdq(p);
          ea.wide_accumulator = {rdq(p + 16'h0001), d};
        end
        p = p + oag_pkg::DOUBLE_STEP;
        if (r.use_third)
          ea.third_pointer_pair = p;
        else
          ea.second_pointer_pair = p;
      end
      oag_pkg::OAG_OP_STORE_BASE:
      begin
        wr(p + {8'h00, r.disp}, ea.acc);
        lat = 3;
      end
      oag_pkg::OAG_OP_STORE_INDEX:
      begin
        case (r.idx)
          oag_pkg::OAG_IDX_ACC: t = {8'h00, ea.acc};
          oag_pkg::OAG_IDX_FIRST: t = {8'h00, eg[0]};
          default: t = ea.wide_accumulator;
        endcase
        wr(ea.third_pointer_pair + t, ea.acc);
        lat = 3;
      end
      oag_pkg::OAG_OP_DEC_WORK:
      begin
        t = {ea.page, r.disp};
        d = rdq(t);
        wr(t, d - 8'h01);
        lat = 4;
      end
      oag_pkg::OAG_OP_TABLE:
      begin
        t = ea.program_counter + oag_pkg::TABLE_OFFSET + {8'h00, ea.acc};
        eg[1] = rdq(t);
        eg[0] = rdq(t + 16'h0001);
      end
      oag_pkg::OAG_OP_IMM:
      begin
        ea.acc = lo;
        ea.program_counter = ea.program_counter + 16'h0001;
        lat = 3;
      end
      oag_pkg::OAG_OP_IMM_WIDE:
      begin
        ea.first_pair = {hi, lo};
        ea.program_counter = ea.program_counter + 16'h0002;
        lat = 4;
      end
      oag_pkg::OAG_OP_DIRECT:
      begin
        ea.acc = rdq({hi, lo});
        ea.program_counter = ea.program_counter + 16'h0002;
      end
      oag_pkg::OAG_OP_MOVE:
      begin
        if (r.reg_sel == 3'h0)
          ea.wide_accumulator[15:8] = ea.acc;
        else if (r.reg_sel == 3'h1)
          ea.wide_accumulator[7:0] = ea.acc;
        else
          eg[r.reg_sel - 3'h2] = ea.acc;
        ea.bypass_flag = 1'b0;
        ea.load_chain_upper = 1'b0;
        ea.load_chain_lower = 1'b0;
      end
      default:
        lat = int'(r.opc_bytes) * 4 + int'(r.imm_bytes) * 3 + 1;
    endcase
  endtask

  // one operation: start held a cycle past the take, which must be refused
  task automatic run_op(input oag_pkg::oag_req_t r, input logic [7:0] lo, input logic [7:0] hi);
    int n;
    int lat;
    obs.delete();
    expq.delete();
    model(r, lo, hi, lat);
    @(posedge mclk);
    start <= 1'b1;
    req <= r;
    imm_byte <= lo;
    @(posedge mclk);
    // the take cycle counts as the first
    n = 1;
    do
    begin
      @(posedge mclk);
      n++;
      if (n == 2)
      begin
        start <= 1'b0;
        imm_byte <= hi;
      end
      #1;
      if (n == 2)
        check("ready while busy", ready, 1'b0);
    end
    while (done !== 1'b1 && n < 200);
    check("latency", n, lat);
    check("ready at done", ready, 1'b1);
    check("transfer count", obs.size(), expq.size());
    foreach (expq[i])
      if (i < obs.size())
        check("transfer", obs[i], expq[i]);
    check("arch", arch, ea);
    foreach (eg[i])
      check("gen_reg", gen_reg[i], eg[i]);
  endtask

  // main sequence: every operation except OAG_OP_NONE in turn, eight rounds with varied fields
  initial
  begin
    oag_pkg::oag_req_t r;
    rstn = 1'b0;
    start = 1'b0;
    req = '0;
    imm_byte = 8'h00;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    ea = '0;
    foreach (eg[i])
      eg[i] = 8'h00;
    void'($urandom(85764));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int k = 0; k < 8; k++)
      for (int o = 1; o <= 13; o++)
      begin
        r = '0;
        r.op = oag_pkg::oag_op_t'(o);
        r.use_third = k[0];
        r.idx = oag_pkg::oag_idx_t'(k % 3);
        r.disp = 8'($urandom) | {k[1], 7'h00};
        r.reg_sel = 3'(k);
        r.push_data = 8'($urandom);
        r.opc_bytes = 3'(1 + $urandom % 3);
        r.imm_bytes = 3'($urandom % 3);
        // round zero pins the one-byte skip, which must match the executed move
        if (k == 0)
        begin
          r.opc_bytes = 3'h1;
          r.imm_bytes = 3'h0;
        end
        run_op(r, 8'($urandom), 8'($urandom));
      end
    tally_and_finish();
  end
endmodule // operand_address_generation_tb_top
